// >>> hw/rsl_pkg.sv
// Shared constants for the strap latch and reduced-interface receive pins.
// Assumes a 10 MHz pclk and a 32-bit APB register bus.
package rsl_pkg;

  // Register byte offsets
  localparam logic [7:0] RSL_ADDR_CTRL = 8'h00;
  localparam logic [7:0] RSL_ADDR_STATUS = 8'h04;
  localparam logic [7:0] RSL_ADDR_DIBITS = 8'h08;
  localparam logic [7:0] RSL_ADDR_FRAMES = 8'h0c;

  // Control field positions and reset value
  localparam int RSL_CTRL_MODE50_BIT = 0;
  localparam int RSL_CTRL_MDIO_LOW_BIT = 1;
  localparam int RSL_CTRL_RX_EN_BIT = 2;
  localparam int RSL_CTRL_W = 3;
  localparam logic [2:0] RSL_CTRL_RST = 3'h4;

  // Status field positions
  localparam int RSL_ST_ADDR_LSB = 0;
  localparam int RSL_ST_DUPLEX_BIT = 5;
  localparam int RSL_ST_DONE_BIT = 6;
  localparam int RSL_ST_MDIO_BIT = 7;
  localparam int RSL_ST_MDC_BIT = 8;
  localparam int RSL_ST_CRS_BIT = 9;

  // Strap pin order: 0 addr bit0, 1 addr bit1, 2 rx data 1 / addr bit2, 3 rx data 0 / duplex
  localparam int RSL_PIN_ADDR0 = 0;
  localparam int RSL_PIN_ADDR1 = 1;
  localparam int RSL_PIN_RXD1 = 2;
  localparam int RSL_PIN_RXD0 = 3;
  localparam int RSL_NPINS = 4;
  localparam logic [3:0] RSL_PULL_UP = 4'h9;
  localparam logic [1:0] RSL_ADDR_HI_RST = 2'h0;

  // Strap settle time before capture
  localparam int RSL_PCLK_NS = 100;
  localparam int RSL_SETTLE_NS = 300;
  localparam int RSL_SETTLE_CYC = (RSL_SETTLE_NS + RSL_PCLK_NS - 1) / RSL_PCLK_NS;

endpackage

// >>> hw/rsl_strap_if.sv
// Carries latched strap values from the latch to the top.
// Assumes both ends sit on pclk.
`timescale 1ns/100ps
interface rsl_strap_if;
  logic [4:0] station_address;
  logic duplex_half;
  logic done;
  modport latch (output station_address, output duplex_half, output done);
  modport user (input station_address, input duplex_half, input done);
endinterface

// >>> hw/rsl_sync.sv
// Two-flop synchroniser, one per bit.
// Assumes inputs come from outside the pclk domain.
`timescale 1ns/100ps
module rsl_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= '0;
      dout <= '0;
    end else begin
      meta_ff <= din;
      dout <= meta_ff;
    end
  end
endmodule

// >>> hw/rsl_strap_latch.sv
// Captures strap levels once after reset release.
// Assumes pins arrive already synchronised and pulls are on until done.
`timescale 1ns/100ps
module rsl_strap_latch (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] pins_sync,
  rsl_strap_if.latch st
);
  import rsl_pkg::*;

  logic [2:0] settle_ff;
  logic [4:0] addr_ff;
  logic duplex_ff;
  logic done_ff;

  // Wait out the synchroniser so reset-time zeros are never latched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_ff <= 3'h0;
    end else if (!done_ff) begin
      settle_ff <= settle_ff + 3'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_ff <= {RSL_ADDR_HI_RST, 3'h0};
      duplex_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (!done_ff && settle_ff == 3'(RSL_SETTLE_CYC)) begin
      addr_ff[0] <= pins_sync[RSL_PIN_ADDR0];
      addr_ff[1] <= pins_sync[RSL_PIN_ADDR1];
      addr_ff[2] <= pins_sync[RSL_PIN_RXD1];
      addr_ff[4:3] <= RSL_ADDR_HI_RST;
      duplex_ff <= pins_sync[RSL_PIN_RXD0];
      done_ff <= 1'b1;
    end
  end

  assign st.station_address = addr_ff;
  assign st.duplex_half = duplex_ff;
  assign st.done = done_ff;
endmodule

// >>> hw/rsl_top.sv
// Strap latch and reduced-interface receive pins with an APB register slave.
// Assumes pclk at 10 MHz, pads resolve pin level from _o/_oe, pulls from pull enables.
`timescale 1ns/100ps
module rsl_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic clock_input_pin,
  output logic ref_clk_out,
  input wire logic [rsl_pkg::RSL_NPINS-1:0] strap_pin_i,
  output logic [rsl_pkg::RSL_NPINS-1:0] strap_pin_o,
  output logic [rsl_pkg::RSL_NPINS-1:0] strap_pin_oe,
  output logic [rsl_pkg::RSL_NPINS-1:0] strap_pull_up,
  output logic [rsl_pkg::RSL_NPINS-1:0] strap_pull_dn,
  output logic crs_dv,
  input wire logic mdc_i,
  input wire logic mdio_i,
  output logic mdio_o,
  output logic mdio_oe,
  input wire logic rcv_valid,
  input wire logic [1:0] rcv_dibit,
  output logic rcv_take
);
  import rsl_pkg::*;

  typedef enum logic {RSL_RX_IDLE, RSL_RX_FRAME} rsl_rx_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and strap capture

  logic [6:0] sync_in;
  logic [6:0] sync_out;
  logic [3:0] pins_sync;
  logic ref_lvl;
  logic mdc_lvl;
  logic mdio_lvl;
  logic ref_d_ff;
  logic ref_rise;

  assign sync_in = {mdio_i, mdc_i, clock_input_pin, strap_pin_i};
  assign pins_sync = sync_out[3:0];
  assign ref_lvl = sync_out[4];
  assign mdc_lvl = sync_out[5];
  assign mdio_lvl = sync_out[6];

  rsl_sync #(.W(7)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .din(sync_in),
    .dout(sync_out)
  );

  rsl_strap_if st_if ();

  rsl_strap_latch u_latch (
    .pclk(pclk),
    .presetn(presetn),
    .pins_sync(pins_sync),
    .st(st_if)
  );

  // Edge finder reads only the second sync stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d_ff <= 1'b0;
    end else begin
      ref_d_ff <= ref_lvl;
    end
  end

  assign ref_rise = ref_lvl & ~ref_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Register state

  logic [RSL_CTRL_W-1:0] ctrl_ff;
  logic [31:0] dibits_ff;
  logic [31:0] frames_ff;
  logic setup;
  logic access;
  logic wr_en;
  logic addr_ok;
  logic [31:0] nxt_rdata;
  logic mode50;
  logic rx_en;

  assign setup = psel & ~penable;
  assign access = psel & penable & pready;
  assign wr_en = access & pwrite & ~pslverr;
  assign mode50 = ctrl_ff[RSL_CTRL_MODE50_BIT];
  assign rx_en = ctrl_ff[RSL_CTRL_RX_EN_BIT];
  assign addr_ok = (paddr == RSL_ADDR_CTRL) || (paddr == RSL_ADDR_STATUS) ||
                   (paddr == RSL_ADDR_DIBITS) || (paddr == RSL_ADDR_FRAMES);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= RSL_CTRL_RST;
    end else if (wr_en && paddr == RSL_ADDR_CTRL) begin
      ctrl_ff <= pwdata[RSL_CTRL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase, data registered at setup

  always_comb begin
    nxt_rdata = 32'h0;
    case (paddr)
      RSL_ADDR_CTRL: begin
        nxt_rdata[RSL_CTRL_W-1:0] = ctrl_ff;
      end
      RSL_ADDR_STATUS: begin
        nxt_rdata[RSL_ST_ADDR_LSB +: 5] = st_if.station_address;
        nxt_rdata[RSL_ST_DUPLEX_BIT] = st_if.duplex_half;
        nxt_rdata[RSL_ST_DONE_BIT] = st_if.done;
        nxt_rdata[RSL_ST_MDIO_BIT] = mdio_lvl;
        nxt_rdata[RSL_ST_MDC_BIT] = mdc_lvl;
        nxt_rdata[RSL_ST_CRS_BIT] = crs_dv;
      end
      RSL_ADDR_DIBITS: begin
        nxt_rdata = dibits_ff;
      end
      RSL_ADDR_FRAMES: begin
        nxt_rdata = frames_ff;
      end
      default: begin
        nxt_rdata = 32'h0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~addr_ok;
      prdata <= pwrite ? 32'h0 : nxt_rdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive path toward the MAC

  rsl_rx_state_t rx_state_ff;
  logic [1:0] rxd_ff;
  logic rx_tick;

  // Nothing is sent until straps are in and pins turned around
  assign rx_tick = ref_rise & st_if.done;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_ff <= RSL_RX_IDLE;
      rxd_ff <= 2'h0;
      crs_dv <= 1'b0;
      rcv_take <= 1'b0;
    end else begin
      rcv_take <= 1'b0;
      if (rx_tick) begin
        case (rx_state_ff)
          RSL_RX_IDLE: begin
            if (rx_en && rcv_valid) begin
              rxd_ff <= rcv_dibit;
              crs_dv <= 1'b1;
              rcv_take <= 1'b1;
              rx_state_ff <= RSL_RX_FRAME;
            end
          end
          RSL_RX_FRAME: begin
            if (rx_en && rcv_valid) begin
              rxd_ff <= rcv_dibit;
              rcv_take <= 1'b1;
            end else begin
              // Frame ends on the first period with no data ready
              rxd_ff <= 2'h0;
              crs_dv <= 1'b0;
              rx_state_ff <= RSL_RX_IDLE;
            end
          end
          default: begin
            rx_state_ff <= RSL_RX_IDLE;
          end
        endcase
      end
    end
  end

  // Counters clear on any write to their own offset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dibits_ff <= 32'h0;
    end else if (wr_en && paddr == RSL_ADDR_DIBITS) begin
      dibits_ff <= 32'h0;
    end else if (rx_tick && rx_en && rcv_valid) begin
      dibits_ff <= dibits_ff + 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frames_ff <= 32'h0;
    end else if (wr_en && paddr == RSL_ADDR_FRAMES) begin
      frames_ff <= 32'h0;
    end else if (rx_tick && rx_en && rcv_valid && rx_state_ff == RSL_RX_IDLE) begin
      frames_ff <= frames_ff + 32'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pin direction, pulls and data

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_pin_oe <= 4'h0;
      strap_pull_up <= RSL_PULL_UP;
      strap_pull_dn <= ~RSL_PULL_UP;
    end else begin
      // Pulls drop in the same edge drivers turn on; never both active
      strap_pin_oe <= {RSL_NPINS{st_if.done}};
      strap_pull_up <= st_if.done ? 4'h0 : RSL_PULL_UP;
      strap_pull_dn <= st_if.done ? 4'h0 : ~RSL_PULL_UP;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_pin_o <= 4'h0;
    end else begin
      strap_pin_o[RSL_PIN_ADDR0] <= 1'b0;
      strap_pin_o[RSL_PIN_ADDR1] <= 1'b0;
      strap_pin_o[RSL_PIN_RXD1] <= rxd_ff[1];
      strap_pin_o[RSL_PIN_RXD0] <= rxd_ff[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reference clock out and management data pin

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_clk_out <= 1'b0;
    end else begin
      ref_clk_out <= mode50 ? 1'b0 : ref_lvl;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mdio_o <= 1'b0;
      mdio_oe <= 1'b0;
    end else begin
      mdio_o <= 1'b0;
      mdio_oe <= ctrl_ff[RSL_CTRL_MDIO_LOW_BIT];
    end
  end

endmodule

// >>> bench/rsl_top_sva.sv
// Checker bound to rsl_top: strap capture and receive pins.
// Assumes pclk edges and async active-low presetn.
`timescale 1ns/100ps
module rsl_top_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [rsl_pkg::RSL_NPINS-1:0] strap_pin_o,
  input wire logic [rsl_pkg::RSL_NPINS-1:0] strap_pin_oe,
  input wire logic [rsl_pkg::RSL_NPINS-1:0] strap_pull_up,
  input wire logic [rsl_pkg::RSL_NPINS-1:0] strap_pull_dn,
  input wire logic crs_dv,
  input wire logic mdio_o,
  input wire logic rcv_valid,
  input wire logic [1:0] rcv_dibit,
  input wire logic rcv_take
);
  import rsl_pkg::*;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  sequence s_settle;
    (strap_pin_oe == 4'h0) [*3];
  endsequence
  a_cap_then_drive: assert property (
    $rose(presetn) |-> s_settle ##[1:4] strap_pin_oe == 4'hf)
    else $error("pins not driven after capture");
  a_pull_in: assert property (
    strap_pin_oe == 4'h0 |-> strap_pull_up == 4'h9 && strap_pull_dn == 4'h6)
    else $error("pulls off while input");
  a_no_overlap: assert property (
    strap_pin_oe != 4'h0 |-> (strap_pull_up | strap_pull_dn) == 4'h0)
    else $error("pull and drive overlap");
  a_oe_held: assert property (
    strap_pin_oe == 4'hf |=> strap_pin_oe == 4'hf)
    else $error("pins fell back to input");
  a_take_once: assert property (
    rcv_take |=> !rcv_take [*6])
    else $error("two dibits in one period");
  a_rxd_dibit: assert property (
    rcv_take |=> strap_pin_o[3:2] == {$past(rcv_dibit[0]), $past(rcv_dibit[1])})
    else $error("data pins wrong");
  a_take_qual: assert property (
    rcv_take |-> crs_dv && $past(rcv_valid))
    else $error("take without valid");
  a_crs_hold: assert property (
    $rose(crs_dv) |=> $stable(crs_dv) [*6])
    else $error("valid changed mid period");
  a_mdio_od: assert property (
    mdio_o == 1'b0)
    else $error("mdio driven high");
endmodule
bind rsl_top rsl_top_sva i_sva (.pclk, .presetn, .strap_pin_o, .strap_pin_oe, .strap_pull_up,
  .strap_pull_dn, .crs_dv, .mdio_o, .rcv_valid, .rcv_dibit, .rcv_take);

// >>> bench/rsl_mac_model.sv
// MAC receive side: samples the data pins on reference rises.
// Assumes pins hold a full reference period.
`timescale 1ns/100ps
module rsl_mac_model (
  input wire logic ref_clk,
  input wire logic crs_dv,
  input wire logic [1:0] rxd
);
  logic [1:0] got[$];
  always @(posedge ref_clk) begin
    if (crs_dv) begin
      got.push_back(rxd);
    end
  end
endmodule

// >>> bench/rsl_top_tb.sv
// Bench for rsl_top: straps, receive pins, control over APB.
// Assumes the MAC samples on the board reference clock.
`timescale 1ns/100ps
module rsl_top_tb;
  import rsl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic clock_input_pin = 1'b0;
  logic mdc_i = 1'b0;
  logic rcv_valid = 1'b0;
  logic [1:0] rcv_dibit = 2'h0;
  logic [3:0] board = 4'h9;
  logic [31:0] prdata;
  logic pready, pslverr, ref_clk_out, crs_dv, mdio_i, mdio_o, mdio_oe, rcv_take;
  logic [3:0] strap_pin_i, strap_pin_o, strap_pin_oe, strap_pull_up, strap_pull_dn;
  int fail_count = 0;
  int n_tests = 0;
  // Board strap shows only while the pin is not driven
  assign strap_pin_i = (strap_pin_oe & strap_pin_o) | (~strap_pin_oe & board);
  assign mdio_i = mdio_oe ? mdio_o : 1'b1;
  always #50 pclk = ~pclk;
  // Free-running oscillator, phase unrelated to pclk
  initial begin
    #137;
    forever #400 clock_input_pin = ~clock_input_pin;
  end
  rsl_top i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
    .pslverr, .clock_input_pin, .ref_clk_out, .strap_pin_i, .strap_pin_o, .strap_pin_oe,
    .strap_pull_up, .strap_pull_dn, .crs_dv, .mdc_i, .mdio_i, .mdio_o, .mdio_oe, .rcv_valid,
    .rcv_dibit, .rcv_take);
  rsl_mac_model i_mac (.ref_clk(clock_input_pin), .crs_dv, .rxd({strap_pin_i[2], strap_pin_i[3]}));
  ////////////////////////////////////////
  task automatic results();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic hang();
    fail_count++;
    results();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) hang();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic send(input logic [1:0] d);
    int k = 0;
    @(posedge pclk);
    rcv_valid <= 1'b1;
    rcv_dibit <= d;
    do begin
      @(negedge pclk);
      k++;
    end while (rcv_take !== 1'b1 && k < 40);
    if (rcv_take !== 1'b1) hang();
  endtask
  task automatic watch_ref(input logic exp);
    logic seen = 1'b0;
    repeat (16) begin
      @(negedge pclk);
      seen = seen | ref_clk_out;
    end
    chk(seen, exp);
  endtask
  ////////////////////////////////////////
  task automatic t_strap(input logic [3:0] b);
    logic [31:0] q;
    logic e;
    board <= b;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({strap_pull_up, strap_pull_dn, strap_pin_oe}, 12'h960);
    presetn <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(strap_pin_oe, 4'hf);
    apb(1'b0, RSL_ADDR_STATUS, 32'h0, q, e);
    chk(q[6:0], {1'b1, b[3], 2'b00, b[2:0]});
    $display("strap test %h done", b);
  endtask
  task automatic t_rx();
    logic [31:0] q, s;
    logic e;
    apb(1'b0, RSL_ADDR_STATUS, 32'h0, s, e);
    apb(1'b1, RSL_ADDR_DIBITS, 32'h0, q, e);
    apb(1'b1, RSL_ADDR_FRAMES, 32'h0, q, e);
    i_mac.got.delete();
    for (int i = 0; i < 4; i++) send(i[1:0]);
    @(posedge pclk);
    rcv_valid <= 1'b0;
    repeat (24) @(posedge pclk);
    chk(i_mac.got.size(), 4);
    for (int i = 0; i < 4; i++) chk(i_mac.got[i], i);
    apb(1'b0, RSL_ADDR_DIBITS, 32'h0, q, e);
    chk(q, 4);
    // One burst of valid dibits is exactly one carrier period
    apb(1'b0, RSL_ADDR_FRAMES, 32'h0, q, e);
    chk(q, 1);
    apb(1'b0, RSL_ADDR_STATUS, 32'h0, q, e);
    chk(q, s);
    $display("receive test done");
  endtask
  task automatic t_ctrl();
    logic [31:0] q;
    logic e;
    // Station raises its management clock; level must reach status
    mdc_i <= 1'b1;
    watch_ref(1'b1);
    apb(1'b1, RSL_ADDR_CTRL, 32'h3, q, e);
    repeat (3) @(posedge pclk);
    chk(mdio_oe, 1'b1);
    watch_ref(1'b0);
    apb(1'b0, RSL_ADDR_STATUS, 32'h0, q, e);
    chk(q[7], 1'b0);
    chk(q[8], 1'b1);
    rcv_valid <= 1'b1;
    repeat (24) @(posedge pclk);
    chk({crs_dv, rcv_take}, 2'b00);
    rcv_valid <= 1'b0;
    apb(1'b0, 8'h10, 32'h0, q, e);
    chk({e, q[7:0]}, 9'h100);
    $display("control test done");
  endtask
  initial begin
    t_strap(4'h9);
    t_strap(4'h6);
    t_rx();
    t_ctrl();
    results();
  end
endmodule
